// file: logic/rmf_pkg.sv
// Constants and types of the RF measure and field detect control block.
// Assumes one 250 MHz system clock and an 8-bit register port with 4-bit addresses.
// Summary of operation
// [RL1] Last 8-bit conversion outcome is kept, replaced by each completed conversion.
// [RL2] Absolute mode spans 00h at 0 V up to FFh, 7.8125 mV steps.
// [RL3] Relative mode, references 1/6 and 5/6 supply, only for phase measurement.
// [RL4] External convert command digitises the analog input pin in absolute mode.
// [RL5] Resonance check converts the phase detector output in relative mode.
// [RL6] Antenna calibration decides on phase detector versus half supply comparator.
// [RL7] Amplitude measure and modulation depth calibration convert the amplitude detector.
// [RL8] Both detectors ORed; each rising edge of that raises the NFC event interrupt.
// [RL9] The two detectors take independent thresholds from the threshold register.
// [RL10] Target activation detector works only while its enable bit is set.
// [RL11] Target activation detector interrupts when a field appears and disappears.
// [RL12] Field present status reads one while target detector exceeds threshold.
// [RL13] Field seen during collision avoidance cancels the send and interrupts.
// [RL14] Collision avoidance precedes each send; target detector off meanwhile.
// [RL15] Oscillator ready interrupt once crystal amplitude passes 750 mVpp.
// [RL16] Internal clock is 13.56 MHz; crystal divide bit halves a 27.12 MHz crystal.
// [RL17] Host clock output is 13.56, 6.78 or 3.39 MHz per configuration field.
// [RL18] Host should clock itself from the host clock output.
// [RL19] Result register is read-only and changes only when a conversion ends.
`default_nettype none
package rmf_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] REG_OP_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CONF2 = 4'h1;
  localparam logic [ADDR_W-1:0] REG_THRESH = 4'h2;
  localparam logic [ADDR_W-1:0] REG_CMD = 4'h3;
  localparam logic [ADDR_W-1:0] REG_ADC_OUT = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATE = 4'h5;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h6;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h7;
  localparam logic [ADDR_W-1:0] REG_ANT_TRIM = 4'h8;
  localparam int OP_TAD_EN_BIT = 0;
  localparam int CONF2_OSC_DIV_BIT = 0;
  localparam int CONF2_MCU_LSB = 1;
  localparam int STATE_RFP_BIT = 0;
  localparam int STATE_BUSY_BIT = 1;
  localparam int THR_TAD_LSB = 0;
  localparam int THR_CAD_LSB = 4;
  localparam logic [7:0] OP_CTRL_RST = 8'h00;
  localparam logic [7:0] CONF2_RST = 8'h00;
  localparam logic [7:0] THRESH_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] CMD_AD_CONVERT = 8'h01;
  localparam logic [7:0] CMD_CHECK_RES = 8'h02;
  localparam logic [7:0] CMD_MEAS_RF = 8'h03;
  localparam logic [7:0] CMD_CAL_MOD = 8'h04;
  localparam logic [7:0] CMD_CAL_ANT = 8'h05;
  localparam logic [7:0] CMD_COLL_AVOID = 8'h06;
  // Interrupt status bit positions
  localparam int IRQ_NFC = 0;
  localparam int IRQ_FIELD_ON = 1;
  localparam int IRQ_FIELD_OFF = 2;
  localparam int IRQ_COLL = 3;
  localparam int IRQ_OSC = 4;
  localparam int IRQ_DONE = 5;
  localparam int IRQ_W = 6;
  localparam int CLK_MHZ = 250;
  localparam int SETTLE_NS = 40;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int CA_WIN_NS = 2000;
  localparam int CA_WIN_CYC = (CA_WIN_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0] SRC_EXT_PIN = 2'h0;
  localparam logic [1:0] SRC_PHASE = 2'h1;
  localparam logic [1:0] SRC_AMPL = 2'h2;
  typedef struct packed {
    logic [1:0] src;
    logic rel_mode;
    logic [7:0] dac;
  } rmf_adc_ctrl_t;
  typedef struct packed {
    logic tad_en;
    logic cad_en;
    logic [3:0] tad_thr;
    logic [3:0] cad_thr;
  } rmf_field_ctrl_t;
endpackage
`default_nettype wire

// file: logic/rmf_ctrl.sv
// Control logic of the reader front end: converter sequencing, field detect,
// collision avoidance, clock division and the register port.
// Assumes analog comparator outputs and the crystal arrive asynchronously.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module rmf_ctrl #(
  parameter int SYNC_IN_W = 6
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [rmf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [rmf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [rmf_pkg::DATA_W-1:0] reg_rdata,
  input wire logic crystal_input,
  input wire logic adc_cmp_hi,
  input wire logic phase_above_half,
  input wire logic tad_detect,
  input wire logic cad_detect,
  input wire logic osc_amp_ok,
  output rmf_pkg::rmf_adc_ctrl_t adc_ctrl,
  output rmf_pkg::rmf_field_ctrl_t field_ctrl,
  output logic [3:0] ant_trim,
  output logic tx_go,
  output logic int_clk,
  output logic mcu_clk,
  output logic irq
);
  import rmf_pkg::*;

  // The synchroniser bank is wired to exactly six asynchronous inputs
  if (SYNC_IN_W != 6) begin : g_bad_width
    $error("rmf_ctrl serves exactly six asynchronous inputs");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_SAR_SET, ST_SAR_DEC, ST_CA} rmf_state_t;

  // Two-stage synchronisers for every asynchronous input
  logic [SYNC_IN_W-1:0] async_in;
  logic [SYNC_IN_W-1:0] meta_q;
  logic [SYNC_IN_W-1:0] sync_q;
  assign async_in = {osc_amp_ok, cad_detect, tad_detect, phase_above_half, adc_cmp_hi,
                     crystal_input};
  for (genvar i = 0; i < SYNC_IN_W; i++) begin : g_sync
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= async_in[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end
  logic xtal_s, cmp_s, phase_s, tad_s, cad_s, osc_s;
  assign {osc_s, cad_s, tad_s, phase_s, cmp_s, xtal_s} = sync_q;

  // Registers
  logic [7:0] op_ctrl_q, conf2_q, thresh_q, adc_out_q, mask_q;
  logic [3:0] trim_q;
  logic [IRQ_W-1:0] irq_stat_q, irq_set;
  logic cmd_we;
  assign cmd_we = reg_we && (reg_addr == REG_CMD);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_ctrl_q <= OP_CTRL_RST;
      conf2_q <= CONF2_RST;
      thresh_q <= THRESH_RST;
      mask_q <= MASK_RST;
    end else if (reg_we) begin
      if (reg_addr == REG_OP_CTRL) op_ctrl_q <= reg_wdata;
      if (reg_addr == REG_CONF2) conf2_q <= reg_wdata;
      if (reg_addr == REG_THRESH) thresh_q <= reg_wdata; // RL9
      if (reg_addr == REG_IRQ_MASK) mask_q <= reg_wdata;
    end
  end

  // Sequencer: successive approximation and collision avoidance
  rmf_state_t state_q;
  logic [7:0] trial_q, bit_q;
  logic [1:0] src_q;
  logic rel_q, ant_mode_q;
  logic [$clog2(CA_WIN_CYC+1)-1:0] cnt_q;
  logic decide;
  logic cad_seen;
  assign decide = ant_mode_q ? phase_s : cmp_s; // RL6

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      trial_q <= 8'h00;
      bit_q <= 8'h00;
      src_q <= SRC_EXT_PIN;
      rel_q <= 1'b0;
      ant_mode_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          cnt_q <= '0;
          if (cmd_we) begin
            ant_mode_q <= 1'b0;
            rel_q <= 1'b0; // RL3
            trial_q <= 8'h80;
            bit_q <= 8'h80;
            state_q <= ST_SAR_SET;
            if (reg_wdata == CMD_AD_CONVERT) begin
              src_q <= SRC_EXT_PIN; // RL4
            end else if (reg_wdata == CMD_CHECK_RES) begin
              src_q <= SRC_PHASE; // RL5
              rel_q <= 1'b1; // RL3
            end else if (reg_wdata == CMD_MEAS_RF || reg_wdata == CMD_CAL_MOD) begin
              src_q <= SRC_AMPL; // RL7
            end else if (reg_wdata == CMD_CAL_ANT) begin
              ant_mode_q <= 1'b1; // RL6
              src_q <= SRC_PHASE;
            end else if (reg_wdata == CMD_COLL_AVOID) begin
              state_q <= ST_CA; // RL14
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_SAR_SET: begin
          // The analog comparator needs time after each trial step
          if (cnt_q == ($bits(cnt_q))'(SETTLE_CYC - 1)) begin
            cnt_q <= '0;
            state_q <= ST_SAR_DEC;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_SAR_DEC: begin
          if (!decide) trial_q <= trial_q & ~bit_q;
          // Antenna trim is only four bits deep
          if (bit_q == 8'h01 || (ant_mode_q && bit_q == 8'h10)) begin
            state_q <= ST_IDLE;
          end else begin
            trial_q <= (decide ? trial_q : (trial_q & ~bit_q)) | (bit_q >> 1);
            bit_q <= bit_q >> 1;
            state_q <= ST_SAR_SET;
          end
        end
        ST_CA: begin
          if (cad_s || cnt_q == ($bits(cnt_q))'(CA_WIN_CYC - 1)) begin
            cnt_q <= '0;
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  logic sar_end;
  logic [7:0] final_code;
  assign sar_end = (state_q == ST_SAR_DEC) &&
                   (bit_q == 8'h01 || (ant_mode_q && bit_q == 8'h10));
  assign final_code = decide ? trial_q : (trial_q & ~bit_q);
  assign cad_seen = (state_q == ST_CA) && cad_s;

  // Result only moves at the end, never during the approximation
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      adc_out_q <= 8'h00;
      trim_q <= 4'h0;
    end else if (sar_end) begin
      if (ant_mode_q) trim_q <= final_code[7:4];
      else adc_out_q <= final_code; // RL1 RL19 RL2
    end
  end

  // Send permitted only when the avoidance window closes clean
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) tx_go <= 1'b0;
    else tx_go <= (state_q == ST_CA) && !cad_s &&
                  (cnt_q == ($bits(cnt_q))'(CA_WIN_CYC - 1)); // RL13
  end

  // Field detection
  logic tad_active, tad_eff, or_q, tad_q, osc_q;
  assign tad_active = op_ctrl_q[OP_TAD_EN_BIT] && (state_q != ST_CA); // RL10 RL14
  assign tad_eff = tad_active && tad_s; // RL12
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      or_q <= 1'b0;
      tad_q <= 1'b0;
      osc_q <= 1'b0;
    end else begin
      or_q <= tad_eff | cad_seen;
      tad_q <= tad_eff;
      osc_q <= osc_s;
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_NFC] = (tad_eff | cad_seen) && !or_q; // RL8
    irq_set[IRQ_FIELD_ON] = tad_eff && !tad_q; // RL11
    irq_set[IRQ_FIELD_OFF] = !tad_eff && tad_q; // RL11
    irq_set[IRQ_COLL] = cad_seen; // RL13
    irq_set[IRQ_OSC] = osc_s && !osc_q; // RL15
    irq_set[IRQ_DONE] = sar_end || tx_go;
  end

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) irq_stat_q <= '0;
    else if (reg_we && reg_addr == REG_IRQ_STAT)
      irq_stat_q <= (irq_stat_q & ~reg_wdata[IRQ_W-1:0]) | irq_set;
    else irq_stat_q <= irq_stat_q | irq_set;
  end
  assign irq = |(irq_stat_q & mask_q[IRQ_W-1:0]);

  // Clock division. Sampling the crystal at 250 MHz limits edge accuracy to 4 ns.
  logic xtal_q, int_q, int_d1_q;
  logic [1:0] mcu_cnt_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xtal_q <= 1'b0;
      int_q <= 1'b0;
    end else begin
      xtal_q <= xtal_s;
      if (conf2_q[CONF2_OSC_DIV_BIT]) begin
        if (xtal_s && !xtal_q) int_q <= !int_q; // RL16
      end else begin
        int_q <= xtal_s;
      end
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_d1_q <= 1'b0;
      mcu_cnt_q <= 2'h0;
      mcu_clk <= 1'b0;
    end else begin
      int_d1_q <= int_q;
      if (int_q && !int_d1_q) mcu_cnt_q <= mcu_cnt_q + 2'h1;
      unique case (conf2_q[CONF2_MCU_LSB +: 2])
        2'h1: mcu_clk <= mcu_cnt_q[0]; // RL17
        2'h2: mcu_clk <= mcu_cnt_q[1]; // RL17
        default: mcu_clk <= int_q; // RL18
      endcase
    end
  end
  assign int_clk = int_q;

  // Register read, one cycle later
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) reg_rdata <= 8'h00;
    else if (reg_re) begin
      unique case (reg_addr)
        REG_OP_CTRL: reg_rdata <= op_ctrl_q;
        REG_CONF2: reg_rdata <= conf2_q;
        REG_THRESH: reg_rdata <= thresh_q;
        REG_ADC_OUT: reg_rdata <= adc_out_q;
        REG_STATE: reg_rdata <= {6'h00, state_q != ST_IDLE, tad_eff}; // RL12
        REG_IRQ_STAT: reg_rdata <= {{(8-IRQ_W){1'b0}}, irq_stat_q};
        REG_IRQ_MASK: reg_rdata <= mask_q;
        REG_ANT_TRIM: reg_rdata <= {4'h0, trim_q};
        default: reg_rdata <= 8'h00;
      endcase
    end else reg_rdata <= 8'h00;
  end

  always_comb begin
    adc_ctrl.src = src_q;
    adc_ctrl.rel_mode = rel_q;
    adc_ctrl.dac = trial_q;
    field_ctrl.tad_en = tad_active;
    field_ctrl.cad_en = (state_q == ST_CA);
    field_ctrl.tad_thr = thresh_q[THR_TAD_LSB +: 4]; // RL9
    field_ctrl.cad_thr = thresh_q[THR_CAD_LSB +: 4]; // RL9
  end
  assign ant_trim = trim_q;
endmodule
`default_nettype wire

// file: tb/rmf_ctrl_properties.sv
// Port-level assertions for rmf_ctrl.
// Assumes the checker is bound to every rmf_ctrl instance.
`timescale 1ns/10ps
`default_nettype none
module rmf_ctrl_chk #(
  parameter int SYNC_IN_W = 6
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [rmf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [rmf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [rmf_pkg::DATA_W-1:0] reg_rdata,
  input wire rmf_pkg::rmf_adc_ctrl_t adc_ctrl,
  input wire rmf_pkg::rmf_field_ctrl_t field_ctrl,
  input wire logic tx_go,
  input wire logic irq
);
  import rmf_pkg::*;
  logic [15:0] run_q;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Length of the last window held so the send pulse can be judged after it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      run_q <= '0;
    else if ($rose(field_ctrl.cad_en))
      run_q <= 16'h0001;
    else if (field_ctrl.cad_en)
      run_q <= run_q + 16'h0001;
  end
  sequence thr_wr;
    reg_we && reg_addr == REG_THRESH;
  endsequence
  chk_thr_split: assert property (thr_wr |=>
    {field_ctrl.cad_thr, field_ctrl.tad_thr} == $past(reg_wdata))
    else $error("threshold split wrong");
  chk_tad_gate: assert property (reg_we && reg_addr == REG_OP_CTRL
    && !reg_wdata[OP_TAD_EN_BIT] |=> !field_ctrl.tad_en) else $error("tad enable ignored");
  chk_ca_tad_off: assert property (field_ctrl.cad_en |-> !field_ctrl.tad_en)
    else $error("tad active in window");
  chk_rel_phase: assert property (adc_ctrl.rel_mode |-> adc_ctrl.src == SRC_PHASE)
    else $error("relative mode off phase");
  chk_go_pulse: assert property (tx_go |=> !tx_go)
    else $error("send pulse too long");
  chk_go_window: assert property (tx_go |-> run_q >= 16'd490)
    else $error("send before full window");
  chk_mask_off: assert property (reg_we && reg_addr == REG_IRQ_MASK && reg_wdata == '0
    |=> !irq) else $error("irq with all masked");
  chk_rdata_idle: assert property (!$past(reg_re) |-> reg_rdata == '0)
    else $error("read data outside slot");
  chk_rdata_unmap: assert property (reg_re && reg_addr > REG_ANT_TRIM |=> reg_rdata == '0)
    else $error("unmapped read nonzero");
endmodule
bind rmf_ctrl rmf_ctrl_chk #(.SYNC_IN_W(SYNC_IN_W)) u_chk (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
  .reg_rdata(reg_rdata), .adc_ctrl(adc_ctrl), .field_ctrl(field_ctrl), .tx_go(tx_go),
  .irq(irq));
`default_nettype wire

// file: tb/rmf_afe_model.sv
// Analog stand-in: answers the converter comparator from input codes.
// Assumes codes are already scaled to the mode the block selects.
`timescale 1ns/10ps
`default_nettype none
module rmf_afe_model (
  input wire rmf_pkg::rmf_adc_ctrl_t adc_ctrl,
  input wire logic [7:0] vin_ext,
  input wire logic [7:0] vin_phase,
  input wire logic [7:0] vin_ampl,
  output logic adc_cmp_hi
);
  import rmf_pkg::*;
  logic [7:0] sel;
  // Phase code stands for a supply-relative reading, so no rescaling here
  assign sel = (adc_ctrl.src == SRC_PHASE) ? vin_phase :
    (adc_ctrl.src == SRC_AMPL) ? vin_ampl : vin_ext;
  assign adc_cmp_hi = (sel >= adc_ctrl.dac);
endmodule
`default_nettype wire

// file: tb/tb_rmf_ctrl.sv
// Self-checking bench for rmf_ctrl.
// Assumes the analog stand-in answers the converter; the bench plays the host.
`timescale 1ns/10ps
`default_nettype none
module tb_rmf_ctrl;
  import rmf_pkg::*;
  logic clk = 0, sys_rst = 1, we = 0, re = 0, xi = 0, pah = 0, tad = 0, cad = 0, osc = 0;
  logic [3:0] addr = '0, xc = '0, trim;
  logic [7:0] wd = '0, rdata, v0 = '0, v1 = '0, v2 = '0, a, b, d, last = '0;
  logic cmp, go, ick, mck, irq, pi, pm;
  logic [1:0] srcx [4] = '{SRC_EXT_PIN, SRC_PHASE, SRC_AMPL, SRC_AMPL};
  logic [7:0] cf [5] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h06};
  rmf_adc_ctrl_t actl;
  rmf_field_ctrl_t fctl;
  int n_fail = 0, total_checks = 0, n, ni, nm, ei, em;
  logic [7:0] exp_q[$];
  always #2 clk = ~clk;
  // Crystal edges come off the clock edge with a 10-cycle period
  always @(posedge clk) begin
    xc <= (xc == 4'h4) ? 4'h0 : xc + 4'h1;
    if (xc == 4'h4)
      xi <= ~xi;
  end
  rmf_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(addr), .reg_wdata(wd), .reg_we(we),
    .reg_re(re), .reg_rdata(rdata), .crystal_input(xi), .adc_cmp_hi(cmp),
    .phase_above_half(pah), .tad_detect(tad), .cad_detect(cad), .osc_amp_ok(osc),
    .adc_ctrl(actl), .field_ctrl(fctl), .ant_trim(trim), .tx_go(go), .int_clk(ick),
    .mcu_clk(mck), .irq(irq));
  rmf_afe_model u_afe (.adc_ctrl(actl), .vin_ext(v0), .vin_phase(v1), .vin_ampl(v2),
    .adc_cmp_hi(cmp));
  task report_and_stop;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm_s, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm_s, e, s);
    end
  endtask
  task wr(input logic [3:0] ad, input logic [7:0] dt);
    @(posedge clk);
    addr <= ad;
    wd <= dt;
    we <= 1;
    @(posedge clk);
    we <= 0;
  endtask
  task rd(input logic [3:0] ad, input logic [7:0] e);
    @(posedge clk);
    addr <= ad;
    re <= 1;
    @(posedge clk);
    re <= 0;
    #1 chk("rdata", rdata, e);
  endtask
  // Count cycles in n until go rises, giving up after lim cycles
  task watch_go(input int lim);
    n = 0;
    #1;
    while (go !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  initial begin
    n = $urandom(27055);
    repeat (6) @(posedge clk);
    sys_rst <= 0;
    foreach (cf[k])
      rd(k == 4 ? 4'hf : k == 3 ? REG_IRQ_MASK : 4'(k), 8'h00);
    wr(REG_ADC_OUT, 8'h5a);
    rd(REG_ADC_OUT, 8'h00);
    wr(REG_IRQ_MASK, 8'h20);
    for (int j = 0; j < 6; j++) begin
      a = (j == 4) ? 8'hff : 8'($urandom);
      b = (j == 5) ? 8'h00 : 8'($urandom);
      d = 8'($urandom);
      v0 <= a;
      v1 <= b;
      v2 <= d;
      exp_q.push_back(j % 4 == 0 ? a : j % 4 == 1 ? b : d);
      wr(REG_CMD, CMD_AD_CONVERT + 8'(j % 4));
      repeat (20) @(posedge clk);
      chk("src", 8'(actl.src), 8'(srcx[j % 4]));
      chk("rel", 8'(actl.rel_mode), 8'(j % 4 == 1));
      rd(REG_ADC_OUT, last);
      rd(REG_STATE, 8'h02);
      repeat (80) @(posedge clk);
      last = exp_q.pop_front();
      rd(REG_ADC_OUT, last);
      chk("irq", 8'(irq), 8'h01);
      wr(REG_IRQ_STAT, 8'h20);
      #1 chk("irq", 8'(irq), 8'h00);
    end
    for (int p = 1; p >= 0; p--) begin
      pah <= p[0];
      wr(REG_CMD, CMD_CAL_ANT);
      repeat (60) @(posedge clk);
      chk("trim", 8'(trim), p ? 8'h0f : 8'h00);
    end
    a = 8'($urandom);
    wr(REG_THRESH, a);
    #1 chk("thr", {fctl.cad_thr, fctl.tad_thr}, a);
    wr(REG_IRQ_STAT, 8'hff);
    for (int e = 1; e >= 0; e--) begin
      wr(REG_OP_CTRL, 8'(e));
      tad <= 1;
      repeat (6) @(posedge clk);
      rd(REG_STATE, 8'(e));
      rd(REG_IRQ_STAT, e ? 8'h03 : 8'h00);
      tad <= 0;
      repeat (6) @(posedge clk);
      rd(REG_STATE, 8'h00);
      rd(REG_IRQ_STAT, e ? 8'h07 : 8'h00);
      wr(REG_IRQ_STAT, 8'hff);
    end
    wr(REG_OP_CTRL, 8'h01);
    wr(REG_CMD, CMD_COLL_AVOID);
    watch_go(700);
    if (n >= 700) begin
      n_fail++;
      report_and_stop();
    end
    chk("ca_len", 8'(n >= 490 && n <= 510), 8'h01);
    rd(REG_IRQ_STAT, 8'h20);
    wr(REG_IRQ_STAT, 8'hff);
    wr(REG_CMD, CMD_COLL_AVOID);
    repeat (100) @(posedge clk);
    cad <= 1;
    watch_go(600);
    chk("no_send", 8'(n >= 600), 8'h01);
    rd(REG_IRQ_STAT, 8'h09);
    cad <= 0;
    wr(REG_IRQ_STAT, 8'hff);
    wr(REG_IRQ_MASK, 8'h10);
    osc <= 1;
    repeat (6) @(posedge clk);
    chk("osc_irq", 8'(irq), 8'h01);
    wr(REG_IRQ_MASK, 8'h00);
    #1 chk("mask_off", 8'(irq), 8'h00);
    wr(REG_IRQ_MASK, 8'h10);
    wr(REG_IRQ_STAT, 8'h10);
    #1 chk("osc_clr", 8'(irq), 8'h00);
    foreach (cf[k]) begin
      wr(REG_CONF2, cf[k]);
      repeat (20) @(posedge clk);
      // Step off the edge so the first sample is not raced by the design's update
      #1;
      ni = 0;
      nm = 0;
      repeat (400) begin
        pi = ick;
        pm = mck;
        @(posedge clk);
        #1 ni += int'(ick & ~pi);
        nm += int'(mck & ~pm);
      end
      ei = cf[k][0] ? 20 : 40;
      em = ei >> (cf[k][2:1] == 2'h1 ? 1 : cf[k][2:1] == 2'h2 ? 2 : 0);
      chk("int_clk", 8'(ni >= ei - 1 && ni <= ei + 1), 8'h01);
      chk("mcu_clk", 8'(nm >= em - 1 && nm <= em + 1), 8'h01);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
